// ### common/rimm_defines.vh
// Register map, field layout and reset values of the receiver interrupt block
`ifndef RIMM_DEFINES_VH
`define RIMM_DEFINES_VH

// Bus geometry
`define RIMM_ADDR_W         8
`define RIMM_DATA_W         32

// Register indices; the byte address is four times the index
`define RIMM_IDX_ENABLE_A   6'h16
`define RIMM_IDX_ENABLE_B   6'h17
`define RIMM_IDX_TRIG_A     6'h18
`define RIMM_IDX_STATUS     6'h20
`define RIMM_IDX_RAW        6'h21

`define RIMM_ADDR_ENABLE_A  {`RIMM_IDX_ENABLE_A, 2'b00}
`define RIMM_ADDR_ENABLE_B  {`RIMM_IDX_ENABLE_B, 2'b00}
`define RIMM_ADDR_TRIG_A    {`RIMM_IDX_TRIG_A, 2'b00}
`define RIMM_ADDR_STATUS    {`RIMM_IDX_STATUS, 2'b00}
`define RIMM_ADDR_RAW       {`RIMM_IDX_RAW, 2'b00}

// Reset values
`define RIMM_RST_ENABLE_A   8'h00
`define RIMM_RST_ENABLE_B   1'b0
`define RIMM_RST_TRIG_A     8'h00
`define RIMM_RST_STATUS     9'h000

// Source bit positions (status, raw and enable layouts)
`define RIMM_SRC_N          9
`define RIMM_BIT_BUF_XFER   0
`define RIMM_BIT_SUB_CRC    1
`define RIMM_BIT_LOCK_LOSS  2
`define RIMM_BIT_SUB_CHG    3
`define RIMM_BIT_BIPHASE    4
`define RIMM_BIT_VALID      5
`define RIMM_BIT_PARITY     6
`define RIMM_BIT_CS_CRC     7
`define RIMM_BIT_OUT_SLIP   8

// Trigger field low bit positions in the first mode register
`define RIMM_POS_SUB_CHG    6
`define RIMM_POS_LOCK_LOSS  4
`define RIMM_POS_SUB_CRC    2
`define RIMM_POS_BUF_XFER   0

// Trigger mode codes
`define RIMM_MODE_RISE      2'h0
`define RIMM_MODE_FALL      2'h1
`define RIMM_MODE_LEVEL     2'h2
`define RIMM_MODE_RSVD      2'h3

`endif

// ### verilog/rimm_trig.v
// Per-source trigger detector: edge or level of one status flag
`timescale 1ns/1ps
`default_nettype none
`include "rimm_defines.vh"

module rimm_trig (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       flag,
    input  wire [1:0] mode,
    output reg        trig
);

    reg prev_reg;

    // Flag as seen one cycle earlier
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= flag;
        end
    end

    // Edge compare against the previous cycle, level passes the flag; reserved code never fires
    always @* begin
        case (mode)
            `RIMM_MODE_RISE: begin
                trig = flag & ~prev_reg;
            end
            `RIMM_MODE_FALL: begin
                trig = ~flag & prev_reg;
            end
            `RIMM_MODE_LEVEL: begin
                trig = flag;
            end
            default: begin
                trig = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

// ### verilog/rimm_top.v
// Receiver interrupt enable, trigger mode and sticky status with APB access
//
// Contract
// - Channel-status CRC interrupt gated by its enable; resets to 0, blocked.
// - Parity error interrupt gated by its enable; resets to 0, blocked.
// - Validity flag interrupt gated by its enable; resets to 0, blocked.
// - Biphase error interrupt gated by its enable; resets to 0, blocked.
// - Subcode change interrupt gated by its enable; resets to 0, blocked.
// - Loss-of-lock interrupt gated by its enable; resets to 0, blocked.
// - Subcode CRC interrupt gated by its enable; resets to 0, blocked.
// - Buffer transfer interrupt gated by its enable; resets to 0, blocked.
// - Output slip enable is bit 0 of second mask; upper bits read zero.
// - Trigger code 0 rising, 1 falling, 2 level, 3 reserved.
// - Loss-of-lock trigger field sits in bits 5:4 of mode register.
// - Subcode CRC field bits 3:2; change 7:6; buffer transfer 1:0.
// - A flag raises an interrupt only while its enable bit is set.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rimm_defines.vh"

module rimm_top (
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [`RIMM_ADDR_W-1:0] paddr,
    input  wire [`RIMM_DATA_W-1:0] pwdata,
    output reg  [`RIMM_DATA_W-1:0] prdata,
    output wire                    pready,
    output reg                     pslverr,
    input  wire                    chan_stat_crc_flag,
    input  wire                    par_err_flag,
    input  wire                    valid_flag,
    input  wire                    biphase_err_flag,
    input  wire                    subcode_change_flag,
    input  wire                    lock_loss_flag,
    input  wire                    subcode_crc_flag,
    input  wire                    buf_xfer_flag,
    input  wire                    out_slip_flag,
    output wire                    irq
);

    localparam N = `RIMM_SRC_N;

    // Software registers
    reg  [7:0]   enable_a_reg;
    reg          enable_b_reg;
    reg  [7:0]   trig_a_reg;
    reg  [N-1:0] status_reg;
    reg  [N-1:0] status_next;

    // Flag synchroniser stages
    reg  [N-1:0] flag_meta_reg;
    reg  [N-1:0] flag_sync_reg;

    // Per-source trigger and mode vectors
    wire [N-1:0]   flag_raw;
    wire [N-1:0]   trig_vec;
    wire [2*N-1:0] mode_vec;
    wire [N-1:0]   en_vec;

    // Named enables, one per source
    wire en_chan_stat_crc_irq;
    wire en_par_err_irq;
    wire en_valid_flag_irq;
    wire en_biphase_err_irq;
    wire en_subcode_change_irq;
    wire en_lock_loss_irq;
    wire en_subcode_crc_irq;
    wire en_buf_xfer_irq;
    wire en_out_slip_irq;

    // Named trigger fields
    wire [1:0] subcode_change_trig_sel;
    wire [1:0] lock_loss_trig_sel;
    wire [1:0] subcode_crc_trig_sel;
    wire [1:0] buf_xfer_trig_sel;

    // Bus decode
    wire       setup_phase;
    wire       access_phase;
    wire       hit_enable_a;
    wire       hit_enable_b;
    wire       hit_trig_a;
    wire       hit_status;
    wire       hit_raw;
    wire       addr_hit;
    wire       wr_fire;
    reg  [`RIMM_DATA_W-1:0] rd_mux;

    // Pack the status flags in the mask register layout
    assign flag_raw[`RIMM_BIT_BUF_XFER]  = buf_xfer_flag;
    assign flag_raw[`RIMM_BIT_SUB_CRC]   = subcode_crc_flag;
    assign flag_raw[`RIMM_BIT_LOCK_LOSS] = lock_loss_flag;
    assign flag_raw[`RIMM_BIT_SUB_CHG]   = subcode_change_flag;
    assign flag_raw[`RIMM_BIT_BIPHASE]   = biphase_err_flag;
    assign flag_raw[`RIMM_BIT_VALID]     = valid_flag;
    assign flag_raw[`RIMM_BIT_PARITY]    = par_err_flag;
    assign flag_raw[`RIMM_BIT_CS_CRC]    = chan_stat_crc_flag;
    assign flag_raw[`RIMM_BIT_OUT_SLIP]  = out_slip_flag;

    // Two-flop synchroniser; the flags come from other clock domains
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_meta_reg <= {N{1'b0}};
            flag_sync_reg <= {N{1'b0}};
        end else begin
            flag_meta_reg <= flag_raw;
            flag_sync_reg <= flag_meta_reg;
        end
    end

    // Enable bits taken from both mask registers
    assign en_chan_stat_crc_irq  = enable_a_reg[`RIMM_BIT_CS_CRC];
    assign en_par_err_irq        = enable_a_reg[`RIMM_BIT_PARITY];
    assign en_valid_flag_irq     = enable_a_reg[`RIMM_BIT_VALID];
    assign en_biphase_err_irq    = enable_a_reg[`RIMM_BIT_BIPHASE];
    assign en_subcode_change_irq = enable_a_reg[`RIMM_BIT_SUB_CHG];
    assign en_lock_loss_irq      = enable_a_reg[`RIMM_BIT_LOCK_LOSS];
    assign en_subcode_crc_irq    = enable_a_reg[`RIMM_BIT_SUB_CRC];
    assign en_buf_xfer_irq       = enable_a_reg[`RIMM_BIT_BUF_XFER];
    assign en_out_slip_irq       = enable_b_reg;

    // Enable vector in status layout
    assign en_vec[`RIMM_BIT_BUF_XFER]  = en_buf_xfer_irq;
    assign en_vec[`RIMM_BIT_SUB_CRC]   = en_subcode_crc_irq;
    assign en_vec[`RIMM_BIT_LOCK_LOSS] = en_lock_loss_irq;
    assign en_vec[`RIMM_BIT_SUB_CHG]   = en_subcode_change_irq;
    assign en_vec[`RIMM_BIT_BIPHASE]   = en_biphase_err_irq;
    assign en_vec[`RIMM_BIT_VALID]     = en_valid_flag_irq;
    assign en_vec[`RIMM_BIT_PARITY]    = en_par_err_irq;
    assign en_vec[`RIMM_BIT_CS_CRC]    = en_chan_stat_crc_irq;
    assign en_vec[`RIMM_BIT_OUT_SLIP]  = en_out_slip_irq;

    // Trigger fields of the first mode register
    assign subcode_change_trig_sel =
        trig_a_reg[`RIMM_POS_SUB_CHG+1:`RIMM_POS_SUB_CHG];
    assign lock_loss_trig_sel =
        trig_a_reg[`RIMM_POS_LOCK_LOSS+1:`RIMM_POS_LOCK_LOSS];
    assign subcode_crc_trig_sel =
        trig_a_reg[`RIMM_POS_SUB_CRC+1:`RIMM_POS_SUB_CRC];
    assign buf_xfer_trig_sel =
        trig_a_reg[`RIMM_POS_BUF_XFER+1:`RIMM_POS_BUF_XFER];

    // Sources without a mode field here stay on the rising-edge default
    assign mode_vec[2*`RIMM_BIT_BUF_XFER+1:2*`RIMM_BIT_BUF_XFER] =
        buf_xfer_trig_sel;
    assign mode_vec[2*`RIMM_BIT_SUB_CRC+1:2*`RIMM_BIT_SUB_CRC] =
        subcode_crc_trig_sel;
    assign mode_vec[2*`RIMM_BIT_LOCK_LOSS+1:2*`RIMM_BIT_LOCK_LOSS] =
        lock_loss_trig_sel;
    assign mode_vec[2*`RIMM_BIT_SUB_CHG+1:2*`RIMM_BIT_SUB_CHG] =
        subcode_change_trig_sel;
    assign mode_vec[2*N-1:2*`RIMM_BIT_BIPHASE] =
        {(N-`RIMM_BIT_BIPHASE){`RIMM_MODE_RISE}};

    // One trigger detector per source
    genvar gi;
    generate
        for (gi = 0; gi < N; gi = gi + 1) begin : g_src
            rimm_trig u_trig (
                .pclk    (pclk),
                .presetn (presetn),
                .flag    (flag_sync_reg[gi]),
                .mode    (mode_vec[2*gi+1:2*gi]),
                .trig    (trig_vec[gi])
            );
        end
    endgenerate

    // APB phase and address decode
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign hit_enable_a = (paddr == `RIMM_ADDR_ENABLE_A);
    assign hit_enable_b = (paddr == `RIMM_ADDR_ENABLE_B);
    assign hit_trig_a   = (paddr == `RIMM_ADDR_TRIG_A);
    assign hit_status   = (paddr == `RIMM_ADDR_STATUS);
    assign hit_raw      = (paddr == `RIMM_ADDR_RAW);
    assign addr_hit     = hit_enable_a | hit_enable_b | hit_trig_a |
                          hit_status | hit_raw;

    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign wr_fire = access_phase & pwrite & addr_hit;

    // Control register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_a_reg <= `RIMM_RST_ENABLE_A;
            enable_b_reg <= `RIMM_RST_ENABLE_B;
            trig_a_reg   <= `RIMM_RST_TRIG_A;
        end else if (wr_fire) begin
            if (hit_enable_a) begin
                enable_a_reg <= pwdata[7:0];
            end
            if (hit_enable_b) begin
                enable_b_reg <= pwdata[0];
            end
            if (hit_trig_a) begin
                trig_a_reg <= pwdata[7:0];
            end
        end
    end

    // Sticky status: a trigger in the clearing cycle wins over the clear
    always @* begin
        status_next = status_reg;
        if (wr_fire && hit_status) begin
            status_next = status_next & ~pwdata[N-1:0];
        end
        status_next = status_next | trig_vec;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= `RIMM_RST_STATUS;
        end else begin
            status_reg <= status_next;
        end
    end

    // Single level request; masked sources stay latched but silent
    assign irq = |(status_reg & en_vec);

    // Read mux; bits above each register's width read as zero
    always @* begin
        rd_mux = {`RIMM_DATA_W{1'b0}};
        if (hit_enable_a) begin
            rd_mux[7:0] = enable_a_reg;
        end
        if (hit_enable_b) begin
            rd_mux[0] = enable_b_reg;
        end
        if (hit_trig_a) begin
            rd_mux[7:0] = trig_a_reg;
        end
        if (hit_status) begin
            rd_mux[N-1:0] = status_reg;
        end
        if (hit_raw) begin
            rd_mux[N-1:0] = flag_sync_reg;
        end
    end

    // Read data and error captured in the setup cycle, valid in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= {`RIMM_DATA_W{1'b0}};
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= pwrite ? {`RIMM_DATA_W{1'b0}} : rd_mux;
            pslverr <= ~addr_hit;
        end
    end

endmodule
`default_nettype wire

// ### tb/rimm_props.sv
// Checker of APB answers and interrupt causes of the receiver interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "rimm_defines.vh"
module rimm_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        chan_stat_crc_flag,
    input wire logic        par_err_flag,
    input wire logic        valid_flag,
    input wire logic        biphase_err_flag,
    input wire logic        subcode_change_flag,
    input wire logic        lock_loss_flag,
    input wire logic        subcode_crc_flag,
    input wire logic        buf_xfer_flag,
    input wire logic        out_slip_flag,
    input wire logic        irq
);
    logic [8:0] flg_q;
    logic [4:0] chg_h;
    logic [2:0] wr_h;
    wire  [8:0] flg = {out_slip_flag, chan_stat_crc_flag, par_err_flag, valid_flag,
        biphase_err_flag, subcode_change_flag, lock_loss_flag, subcode_crc_flag, buf_xfer_flag};
    wire        setup = psel && !penable;
    wire        mapped = paddr == `RIMM_ADDR_ENABLE_A || paddr == `RIMM_ADDR_ENABLE_B ||
        paddr == `RIMM_ADDR_TRIG_A || paddr == `RIMM_ADDR_STATUS || paddr == `RIMM_ADDR_RAW;
    // Recent flag changes and writes, the only things that may move irq
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flg_q <= 9'h000;
            chg_h <= 5'h00;
            wr_h  <= 3'h0;
        end else begin
            flg_q <= flg;
            chg_h <= {chg_h[3:0], flg != flg_q};
            wr_h  <= {wr_h[1:0], psel && penable && pwrite};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_slip_upper_zero: assert property (
        setup && !pwrite && paddr == `RIMM_ADDR_ENABLE_B |=> prdata[31:1] == 31'h0)
        else $error("enable_b upper bits set");
    a_mode_upper_zero: assert property (
        setup && !pwrite && paddr == `RIMM_ADDR_TRIG_A |=> prdata[31:8] == 24'h0)
        else $error("trig_a upper bits set");
    a_mask_upper_zero: assert property (
        setup && !pwrite && paddr == `RIMM_ADDR_ENABLE_A |=> prdata[31:8] == 24'h0)
        else $error("enable_a upper bits set");
    a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    a_wr_rdata_zero: assert property (setup && pwrite |=> prdata == 32'h0)
        else $error("read data not zero on write");
    a_irq_rise_cause: assert property ($rose(irq) |-> (|wr_h) || (|chg_h))
        else $error("irq rose without cause");
    a_irq_fall_cause: assert property ($fell(irq) |-> |wr_h)
        else $error("irq fell without write");
    cover property ($rose(irq));
    cover property (setup ##1 pslverr);
    cover property (setup && pwrite && paddr == `RIMM_ADDR_STATUS);
endmodule
bind rimm_top rimm_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pslverr, .chan_stat_crc_flag, .par_err_flag, .valid_flag, .biphase_err_flag,
    .subcode_change_flag, .lock_loss_flag, .subcode_crc_flag, .buf_xfer_flag,
    .out_slip_flag, .irq);
`default_nettype wire

// ### tb/rimm_flag_src.sv
// Model of the receiver front end that drives the nine status flags
`timescale 1ns/1ps
`default_nettype none
module rimm_flag_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [8:0] cmd,
    output var  logic [8:0] flags
);
    // Flags move just after an edge, as a clocked front end would
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= 9'h000;
        end else begin
            flags <= cmd;
        end
    end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench of the receiver interrupt block with a reference model
`timescale 1ns/1ps
`default_nettype none
`include "rimm_defines.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, rv;
    logic        pready, pslverr, irq, err;
    logic [8:0]  cmd = 9'h000;
    logic [8:0]  flags, old;
    int          miscompares = 0;
    int          n_compared = 0;
    int          en, mode, st;
    always #2.5 pclk = ~pclk;
    rimm_flag_src SRC (.pclk(pclk), .presetn(presetn), .cmd(cmd), .flags(flags));
    rimm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_stat_crc_flag(flags[7]), .par_err_flag(flags[6]),
        .valid_flag(flags[5]), .biphase_err_flag(flags[4]), .subcode_change_flag(flags[3]),
        .lock_loss_flag(flags[2]), .subcode_crc_flag(flags[1]), .buf_xfer_flag(flags[0]),
        .out_slip_flag(flags[8]), .irq(irq));
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One APB transfer; the wait for pready is bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 8) begin miscompares++; stop_test(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [7:0] a, input int e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    // Drive the flags and let the model decide which sources trigger
    task automatic step(input logic [8:0] v);
        int m;
        cmd <= v;
        for (int i = 0; i < 9; i++) begin
            m = i < 4 ? (mode >> (2 * i)) & 3 : 0;
            if ((m == 0 && v[i] && !old[i]) || (m == 1 && !v[i] && old[i]) || (m == 2 && v[i]))
                st |= 1 << i;
        end
        old = v;
        repeat (6) @(posedge pclk);
    endtask
    task automatic chk;
        rdc(`RIMM_ADDR_STATUS, st, "status");
        `CHK("irq", 1'((st & en) != 0), irq)
    endtask
    task automatic wen(input int e);
        apb(1'b1, `RIMM_ADDR_ENABLE_A, e & 'hFF);
        apb(1'b1, `RIMM_ADDR_ENABLE_B, e >> 8);
        en = e;
    endtask
    task automatic clr;
        apb(1'b1, `RIMM_ADDR_STATUS, 32'h1FF);
        st = 0;
    endtask
    initial begin
        rv = $urandom(23);
        en = 0;
        mode = 0;
        st = 0;
        old = 9'h000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(`RIMM_ADDR_ENABLE_A, 0, "enable_a");
        rdc(`RIMM_ADDR_ENABLE_B, 0, "enable_b");
        rdc(`RIMM_ADDR_TRIG_A, 0, "trig_a");
        chk();
        $display("test reset done");
        // Random register contents, then an unmapped place
        repeat (4) begin
            rv = $urandom;
            apb(1'b1, `RIMM_ADDR_ENABLE_A, rv);
            rdc(`RIMM_ADDR_ENABLE_A, rv & 'hFF, "enable_a");
            apb(1'b1, `RIMM_ADDR_ENABLE_B, rv);
            rdc(`RIMM_ADDR_ENABLE_B, rv & 1, "enable_b");
            apb(1'b1, `RIMM_ADDR_TRIG_A, rv);
            rdc(`RIMM_ADDR_TRIG_A, rv & 'hFF, "trig_a");
        end
        rdc(8'h40, 0, "unmapped");
        `CHK("slverr", 1'b1, err)
        wen(0);
        apb(1'b1, `RIMM_ADDR_TRIG_A, 32'h0);
        $display("test registers done");
        // Each source latches while masked and drives irq only once enabled
        for (int i = 0; i < 9; i++) begin
            step(9'h1 << i);
            chk();
            wen(1 << i);
            chk();
            step(9'h000);
            clr();
            chk();
            wen(0);
        end
        $display("test masks done");
        // Distinct code in each field so a swapped field shows
        wen('h1FF);
        for (int m = 0; m < 4; m++) begin
            mode = 0;
            for (int k = 0; k < 4; k++) mode |= ((m + k) % 4) << (2 * k);
            apb(1'b1, `RIMM_ADDR_TRIG_A, mode);
            step(9'h1FF);
            chk();
            step(9'h000);
            chk();
            clr();
            chk();
        end
        mode = $urandom & 'hFF;
        apb(1'b1, `RIMM_ADDR_TRIG_A, mode);
        repeat (6) begin
            step($urandom & 'h1FF);
            chk();
            rdc(`RIMM_ADDR_RAW, old, "raw");
        end
        $display("test modes done");
        // Reset in mid-run must bring every register back to its default
        cmd <= 9'h000;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        old = 9'h000;
        st = 0;
        en = 0;
        mode = 0;
        rdc(`RIMM_ADDR_ENABLE_A, 0, "enable_a");
        rdc(`RIMM_ADDR_ENABLE_B, 0, "enable_b");
        rdc(`RIMM_ADDR_TRIG_A, 0, "trig_a");
        chk();
        $display("test mid reset done");
        stop_test();
    end
endmodule
`default_nettype wire
